/* File: inc/spcr_pkg.sv */
// Summary of operation
// - Eight-bit storage registers, freely read and written.
// - Accumulator has no register address.
// - Bit 7 picks external interrupt edge.
// - Bit 5 picks internal or external count.
// - Shared pin: comparator, then counter, then port.
// - Bit 4 picks external count edge.
// - Bit 3 enables prescaler, else 1:1.
// - Divider code 000..111 gives 1:2..1:256.
// - Port 5 direction: 0 output, 1 high-Z.
// - Port 6 direction: 0 output, 1 high-Z.
// - PWM count top bits read-only, 7:6 zero.
// - PWM count low byte read-only.
// - Ten-bit period sets PWM time base.
// - PWM high until count equals duty.
// - Pull-down bits active low, bit 7 zero.
// - Pull-down register reads back last write.
// - Open-drain bits active high, bit 3 zero.
// - Open-drain register reads back last write.
`default_nettype none
package spcr_pkg;
    // ========================================
    // Register map
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  GEN_FIRST     = 8'h10;
    localparam logic [7:0]  GEN_LAST      = 8'h3f;
    localparam int unsigned GEN_DEPTH     = 48;
    localparam logic [7:0]  TIMER_CFG_A   = 8'h40;
    localparam logic [7:0]  PORT5_DIR_A   = 8'h45;
    localparam logic [7:0]  PORT6_DIR_A   = 8'h46;
    localparam logic [7:0]  PWM_HIGH_A    = 8'h47;
    localparam logic [7:0]  PWM_CNT_LO_A  = 8'h48;
    localparam logic [7:0]  PWM_PRD_LO_A  = 8'h49;
    localparam logic [7:0]  PWM_DUTY_LO_A = 8'h4a;
    localparam logic [7:0]  PULL_DOWN_A   = 8'h4b;
    localparam logic [7:0]  OPEN_DRAIN_A  = 8'h4c;
    // ========================================
    // Field positions
    localparam int unsigned EDGE_SEL_BIT  = 7;
    localparam int unsigned GIE_BIT       = 6;
    localparam int unsigned SRC_SEL_BIT   = 5;
    localparam int unsigned CNT_EDGE_BIT  = 4;
    localparam int unsigned DIV_EN_BIT    = 3;
    // ========================================
    // Reset values and write masks
    localparam logic [7:0]  TIMER_CFG_RST = 8'h00;
    localparam logic [5:0]  PORT5_DIR_RST = 6'h3f;
    localparam logic [7:0]  PORT6_DIR_RST = 8'hff;
    localparam logic [9:0]  PWM_PRD_RST   = 10'h3ff;
    localparam logic [9:0]  PWM_DUTY_RST  = 10'h000;
    localparam logic [7:0]  PULL_DOWN_RST = 8'h7f;
    localparam logic [7:0]  PULL_DOWN_MSK = 8'h7f;
    localparam logic [7:0]  OPEN_DRN_RST  = 8'h00;
    localparam logic [7:0]  OPEN_DRN_MSK  = 8'hf7;
    localparam logic [7:0]  UNMAPPED_RD   = 8'h00;
endpackage
`default_nettype wire

/* File: rtl/spcr_regs.sv */
// Decided for this implementation: the address-and-strobe port and the register addresses.
`default_nettype none
module spcr_regs #(
    parameter int unsigned PWM_W = 10
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Core instruction events, one-cycle pulses
    input  wire logic              irq_disable_instr,
    input  wire logic              irq_enable_instr,
    input  wire logic              irq_return_instr,
    input  wire logic              hw_irq_entry,
    // Counter and interrupt inputs
    input  wire logic              instr_cycle_tick,
    input  wire logic              port6_bit2_pin,
    input  wire logic              ext_irq_pin,
    input  wire logic              comparator_neg_input_a,
    input  wire logic              pwm_clk_tick,
    // Control outputs
    output logic                   global_irq_enable,
    output logic                   ext_irq_event,
    output logic                   timer_counter_tick,
    output logic                   port6_bit2_is_comp,
    output logic                   port6_bit2_is_counter,
    output logic [5:0]             port5_dir_bits,
    output logic [7:0]             port6_dir_bits,
    output logic [5:0]             port5_out_en,
    output logic [7:0]             port6_out_en,
    output logic [7:0]             pulldown_off_bit,
    output logic [7:0]             open_drain_select,
    output logic                   pwm_out
);

    // ========================================
    // Storage and control registers
    logic [7:0]       gen_mem [spcr_pkg::GEN_DEPTH];
    logic [7:0]       timer_cfg_r;
    logic             gie_r;
    logic [5:0]       p5_dir_r;
    logic [7:0]       p6_dir_r;
    logic [PWM_W-1:0] prd_r;
    logic [PWM_W-1:0] duty_r;
    logic [PWM_W-1:0] cnt_r;
    logic [PWM_W-1:0] cnt_nxt;
    logic [7:0]       pd_r;
    logic [7:0]       od_r;
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic             gen_hit;
    logic [5:0]       gen_idx;

    assign gen_hit = (reg_addr >= spcr_pkg::GEN_FIRST) && (reg_addr <= spcr_pkg::GEN_LAST);
    assign gen_idx = 6'(reg_addr - spcr_pkg::GEN_FIRST);

    // ========================================
    // General storage, no reset needed for plain data
    always_ff @(posedge sys_clk) begin
        if (reg_wr && gen_hit) begin
            gen_mem[gen_idx] <= reg_wdata;
        end
    end

    // ========================================
    // Configuration written by software
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer_cfg_r <= spcr_pkg::TIMER_CFG_RST;
            p5_dir_r    <= spcr_pkg::PORT5_DIR_RST;
            p6_dir_r    <= spcr_pkg::PORT6_DIR_RST;
            prd_r       <= spcr_pkg::PWM_PRD_RST;
            duty_r      <= spcr_pkg::PWM_DUTY_RST;
            pd_r        <= spcr_pkg::PULL_DOWN_RST;
            od_r        <= spcr_pkg::OPEN_DRN_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                spcr_pkg::TIMER_CFG_A:   timer_cfg_r <= reg_wdata;
                spcr_pkg::PORT5_DIR_A:   p5_dir_r    <= reg_wdata[5:0];
                spcr_pkg::PORT6_DIR_A:   p6_dir_r    <= reg_wdata;
                spcr_pkg::PWM_HIGH_A: begin
                    prd_r[9:8]  <= reg_wdata[3:2];
                    duty_r[9:8] <= reg_wdata[1:0];
                end
                spcr_pkg::PWM_PRD_LO_A:  prd_r[7:0]  <= reg_wdata;
                spcr_pkg::PWM_DUTY_LO_A: duty_r[7:0] <= reg_wdata;
                spcr_pkg::PULL_DOWN_A:   pd_r <= reg_wdata & spcr_pkg::PULL_DOWN_MSK;
                spcr_pkg::OPEN_DRAIN_A:  od_r <= reg_wdata & spcr_pkg::OPEN_DRN_MSK;
                default: begin
                end
            endcase
        end
    end

    // ========================================
    // Global interrupt enable, only instructions and hardware interrupt entry move it
    // Set wins so an enable in the same cycle is never lost
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            gie_r <= 1'b0;
        end else if (irq_enable_instr || irq_return_instr) begin
            gie_r <= 1'b1;
        end else if (irq_disable_instr || hw_irq_entry) begin
            gie_r <= 1'b0;
        end
    end

    // ========================================
    // Pin synchronisers, first stage read only by second
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
        end else begin
            sync1_r <= {comparator_neg_input_a, ext_irq_pin, port6_bit2_pin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    logic comp_a;
    logic irq_rise;
    logic irq_fall;
    logic pin_rise;
    logic pin_fall;
    assign comp_a   = sync2_r[2];
    assign irq_rise = sync2_r[1] & ~sync3_r[1];
    assign irq_fall = ~sync2_r[1] & sync3_r[1];
    assign pin_rise = sync2_r[0] & ~sync3_r[0];
    assign pin_fall = ~sync2_r[0] & sync3_r[0];

    // ========================================
    // External interrupt edge detect
    logic ext_evt_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ext_evt_r <= 1'b0;
        end else begin
            ext_evt_r <= timer_cfg_r[spcr_pkg::EDGE_SEL_BIT] ? irq_fall : irq_rise;
        end
    end

    // ========================================
    // Shared pin function; comparator claim outranks counter
    logic is_comp_r;
    logic is_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            is_comp_r <= 1'b0;
            is_cnt_r  <= 1'b0;
        end else begin
            is_comp_r <= comp_a;
            is_cnt_r  <= ~comp_a & timer_cfg_r[spcr_pkg::SRC_SEL_BIT];
        end
    end

    // ========================================
    // Counter source and prescaler
    logic       raw_evt;
    logic       ext_edge;
    logic [7:0] pre_r;
    logic [7:0] pre_lim;
    logic       tick_r;
    assign ext_edge = timer_cfg_r[spcr_pkg::CNT_EDGE_BIT] ? pin_fall : pin_rise;
    // Counter input is dead while the comparator owns the pin
    assign raw_evt  = timer_cfg_r[spcr_pkg::SRC_SEL_BIT] ? (ext_edge & is_cnt_r)
                                                         : instr_cycle_tick;
    assign pre_lim  = 8'((16'h2 << timer_cfg_r[2:0]) - 16'h1);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pre_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (!timer_cfg_r[spcr_pkg::DIV_EN_BIT]) begin
            pre_r  <= 8'h00;
            tick_r <= raw_evt;
        end else if (raw_evt) begin
            if (pre_r >= pre_lim) begin
                pre_r  <= 8'h00;
                tick_r <= 1'b1;
            end else begin
                pre_r  <= pre_r + 8'h01;
                tick_r <= 1'b0;
            end
        end else begin
            tick_r <= 1'b0;
        end
    end

    // ========================================
    // PWM time base; output follows count against duty
    always_comb begin
        cnt_nxt = cnt_r;
        if (pwm_clk_tick) begin
            if (cnt_r >= prd_r) begin
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + PWM_W'(1);
            end
        end
    end

    logic pwm_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_r <= '0;
            pwm_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pwm_r <= (cnt_nxt < duty_r);
        end
    end

    // ========================================
    // Read mux; accumulator deliberately has no address
    always_comb begin
        rdata_nxt = spcr_pkg::UNMAPPED_RD;
        if (gen_hit) begin
            rdata_nxt = gen_mem[gen_idx];
        end else begin
            case (reg_addr)
                spcr_pkg::TIMER_CFG_A:   rdata_nxt = {timer_cfg_r[7], gie_r, timer_cfg_r[5:0]};
                spcr_pkg::PORT5_DIR_A:   rdata_nxt = {2'b00, p5_dir_r};
                spcr_pkg::PORT6_DIR_A:   rdata_nxt = p6_dir_r;
                spcr_pkg::PWM_HIGH_A:    rdata_nxt = {2'b00, cnt_r[9:8], prd_r[9:8], duty_r[9:8]};
                spcr_pkg::PWM_CNT_LO_A:  rdata_nxt = cnt_r[7:0];
                spcr_pkg::PWM_PRD_LO_A:  rdata_nxt = prd_r[7:0];
                spcr_pkg::PWM_DUTY_LO_A: rdata_nxt = duty_r[7:0];
                spcr_pkg::PULL_DOWN_A:   rdata_nxt = pd_r;
                spcr_pkg::OPEN_DRAIN_A:  rdata_nxt = od_r;
                default:                 rdata_nxt = spcr_pkg::UNMAPPED_RD;
            endcase
        end
    end

    // Read data held only one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

    // ========================================
    // Pin enables registered so outputs come from flops
    logic [5:0] p5_oe_r;
    logic [7:0] p6_oe_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            p5_oe_r <= 6'h00;
            p6_oe_r <= 8'h00;
        end else begin
            p5_oe_r <= ~p5_dir_r;
            p6_oe_r <= ~p6_dir_r;
        end
    end

    assign reg_rdata             = rdata_r;
    assign global_irq_enable     = gie_r;
    assign ext_irq_event         = ext_evt_r;
    assign timer_counter_tick    = tick_r;
    assign port6_bit2_is_comp    = is_comp_r;
    assign port6_bit2_is_counter = is_cnt_r;
    assign port5_dir_bits        = p5_dir_r;
    assign port6_dir_bits        = p6_dir_r;
    assign port5_out_en          = p5_oe_r;
    assign port6_out_en          = p6_oe_r;
    assign pulldown_off_bit      = pd_r;
    assign open_drain_select     = od_r;
    assign pwm_out               = pwm_r;

    // ========================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_gie_set_wins: assert property ((irq_enable_instr || irq_return_instr) |=> gie_r)
        else $error("global enable not set");
    a_gie_clear: assert property ((irq_disable_instr && !irq_enable_instr && !irq_return_instr) |=> !gie_r)
        else $error("global enable not cleared");
    a_gie_write_ignored: assert property ((!irq_enable_instr && !irq_return_instr && !irq_disable_instr
        && !hw_irq_entry) |=> $stable(gie_r))
        else $error("global enable moved without instruction");
    a_port_out_en: assert property (##1 (p6_oe_r == ~$past(p6_dir_r)) && (p5_oe_r == ~$past(p5_dir_r)))
        else $error("port enable does not follow direction");
    a_high_byte_zero: assert property ((reg_rd && reg_addr == spcr_pkg::PWM_HIGH_A)
        |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:4] == $past(cnt_r[9:8]))
        else $error("pwm high byte read wrong");
    a_count_ro: assert property ((reg_wr && reg_addr == spcr_pkg::PWM_CNT_LO_A && !pwm_clk_tick)
        |=> $stable(cnt_r))
        else $error("write moved pwm count");
    a_pwm_wrap: assert property ((pwm_clk_tick && cnt_r == prd_r) |=> cnt_r == '0 && pwm_r == (duty_r != '0))
        else $error("pwm count did not wrap");
    a_pwm_low_at_duty: assert property ((cnt_r >= duty_r) && !pwm_clk_tick |=> !pwm_r)
        else $error("pwm high past duty");
    a_pd_readback: assert property ((reg_wr && reg_addr == spcr_pkg::PULL_DOWN_A) ##1 (reg_rd && reg_addr
        == spcr_pkg::PULL_DOWN_A && !reg_wr) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f))
        else $error("pull-down readback wrong");
    a_od_bit3_zero: assert property (od_r[3] == 1'b0)
        else $error("open-drain bit 3 set");
    a_comp_priority: assert property (is_comp_r |-> !is_cnt_r)
        else $error("counter owns pin under comparator");
    a_undivided_tick: assert property ((!timer_cfg_r[spcr_pkg::DIV_EN_BIT] && !timer_cfg_r[spcr_pkg::SRC_SEL_BIT]
        && instr_cycle_tick) |=> tick_r)
        else $error("undivided tick missing");
    a_pd_bit7_zero: assert property (pd_r[7] == 1'b0)
        else $error("pull-down bit 7 set");
    // Idle read data must be zero so a late sample cannot pass by luck
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stands without strobe");

    c_pwm_wrap:  cover property (pwm_clk_tick && cnt_r == prd_r);
    c_ext_edge:  cover property (ext_evt_r);
    c_div_tick:  cover property (timer_cfg_r[spcr_pkg::DIV_EN_BIT] && tick_r);
    c_gen_read:  cover property (reg_rd && gen_hit);
    c_wr_rd:     cover property (reg_wr ##1 reg_rd);

endmodule
`default_nettype wire

/* File: test/spcr_tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Design connections
    logic       sys_clk, rstn, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic [5:0] ev;  // Pulses: pwm, instr, entry, return, enable, disable
    logic       cnt_pin, irq_pin, comp_own;
    logic       gie, irq_ev, cnt_tick, is_comp, is_cnt, pwm_out;
    logic [5:0] p5_dir, p5_oe;
    logic [7:0] p6_dir, p6_oe, pd_bits, od_bits;
    int         miscompares, total_checks, n_tick, n_irq, n_hi;

    spcr_regs i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_disable_instr(ev[0]), .irq_enable_instr(ev[1]), .irq_return_instr(ev[2]),
        .hw_irq_entry(ev[3]), .instr_cycle_tick(ev[4]), .pwm_clk_tick(ev[5]),
        .port6_bit2_pin(cnt_pin), .ext_irq_pin(irq_pin), .comparator_neg_input_a(comp_own),
        .global_irq_enable(gie), .ext_irq_event(irq_ev), .timer_counter_tick(cnt_tick),
        .port6_bit2_is_comp(is_comp), .port6_bit2_is_counter(is_cnt),
        .port5_dir_bits(p5_dir), .port6_dir_bits(p6_dir), .port5_out_en(p5_oe),
        .port6_out_en(p6_oe), .pulldown_off_bit(pd_bits), .open_drain_select(od_bits),
        .pwm_out(pwm_out)
    );

    // ========================================
    // Clock and event monitors
    always #10 sys_clk = ~sys_clk;
    // Registered pulses are counted on the edge after they rise
    always @(posedge sys_clk) begin
        if (cnt_tick === 1'b1) n_tick = n_tick + 1;
        if (irq_ev === 1'b1) n_irq = n_irq + 1;
    end

    // ========================================
    // Shared tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Data is registered at the taking edge and stands one cycle
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    // Write at one edge, read at the next, data in the cycle after
    task wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    // One-cycle event pulse, then one settling cycle
    task pulse(input int b);
        @(posedge sys_clk);
        ev[b] <= 1'b1;
        @(posedge sys_clk);
        ev[b] <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    // Pins are synchronised inside, so give them several cycles
    task pins(input logic c, input logic i, input logic o);
        @(posedge sys_clk);
        cnt_pin <= c;
        irq_pin <= i;
        comp_own <= o;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task print_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========================================
    // Scenarios
    task t_reset;
        rd(spcr_pkg::TIMER_CFG_A);  chk(rd_val, spcr_pkg::TIMER_CFG_RST, "cfg rst");
        rd(spcr_pkg::PORT5_DIR_A);  chk(rd_val, 8'h3f, "p5 rst");
        rd(spcr_pkg::PORT6_DIR_A);  chk(rd_val, 8'hff, "p6 rst");
        rd(spcr_pkg::PULL_DOWN_A);  chk(rd_val, 8'h7f, "pd rst");
        rd(spcr_pkg::OPEN_DRAIN_A); chk(rd_val, 8'h00, "od rst");
        chk({p5_oe, p6_oe}, 16'h0000, "oe rst");
        chk({gie, pwm_out, is_cnt}, 16'h0000, "lvl rst");
    endtask
    // Storage edges, and an unmapped place where no accumulator lives
    task t_storage;
        wr(spcr_pkg::GEN_FIRST, 8'h5a);
        wr(spcr_pkg::GEN_LAST, 8'ha3);
        wr(8'h00, 8'hc3);
        rd(spcr_pkg::GEN_FIRST); chk(rd_val, 8'h5a, "gen lo");
        rd(spcr_pkg::GEN_LAST);  chk(rd_val, 8'ha3, "gen hi");
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, 8'h00, "rdata idle");
        rd(8'h00); chk(rd_val, 8'h00, "unmapped");
    endtask
    task t_dirs;
        wr(spcr_pkg::PORT5_DIR_A, 8'hea);
        wr(spcr_pkg::PORT6_DIR_A, 8'h5a);
        rd(spcr_pkg::PORT5_DIR_A); chk(rd_val, 8'h2a, "p5 rb");
        rd(spcr_pkg::PORT6_DIR_A); chk(rd_val, 8'h5a, "p6 rb");
        chk({p5_dir, p5_oe}, {6'h2a, 6'h15}, "p5 pins");
        chk({p6_dir, p6_oe}, 16'h5aa5, "p6 pins");
    endtask
    // Unused bits hold zero whatever is written
    task t_pads;
        wr(spcr_pkg::PULL_DOWN_A, 8'hff);
        wr(spcr_pkg::OPEN_DRAIN_A, 8'hff);
        rd(spcr_pkg::PULL_DOWN_A);  chk(rd_val, 8'h7f, "pd ff");
        rd(spcr_pkg::OPEN_DRAIN_A); chk(rd_val, 8'hf7, "od ff");
        chk({pd_bits, od_bits}, 16'h7ff7, "pad pins");
        // Write then read with no gap between the strobes
        wr_rd(spcr_pkg::PULL_DOWN_A, 8'h00); chk(rd_val, 8'h00, "pd 00");
        wr_rd(spcr_pkg::OPEN_DRAIN_A, 8'h5a); chk(rd_val, 8'h52, "od 5a");
    endtask
    task t_gie;
        wr(spcr_pkg::TIMER_CFG_A, 8'hff);
        rd(spcr_pkg::TIMER_CFG_A); chk(rd_val, 8'hbf, "cfg wr");
        pulse(1); chk(gie, 1'b1, "eni");
        rd(spcr_pkg::TIMER_CFG_A); chk(rd_val, 8'hff, "cfg gie");
        pulse(0); chk(gie, 1'b0, "irq_disable_instr");
        pulse(2); chk(gie, 1'b1, "irq_return_instr");
        pulse(3); chk(gie, 1'b0, "entry");
    endtask
    task t_prescale;
        wr(spcr_pkg::TIMER_CFG_A, 8'h00);
        n_tick = 0;
        repeat (5) pulse(4);
        chk(n_tick, 5, "no div");
        // Any window of two whole divider periods holds two ticks
        for (int k = 0; k < 8; k++) begin
            wr(spcr_pkg::TIMER_CFG_A, 8'h08 | k[7:0]);
            repeat (2 << k) pulse(4);
            repeat (3) @(posedge sys_clk);
            n_tick = 0;
            repeat (4 << k) pulse(4);
            repeat (3) @(posedge sys_clk);
            chk(n_tick, 2, "div");
        end
    endtask
    task t_ext_count;
        wr(spcr_pkg::TIMER_CFG_A, 8'h20);
        pins(0, 0, 0); chk(is_cnt, 1'b1, "src ext");
        n_tick = 0;
        pins(1, 0, 0); chk(n_tick, 1, "rise");
        pins(0, 0, 0); pulse(4); chk(n_tick, 1, "fall");
        wr(spcr_pkg::TIMER_CFG_A, 8'h30);
        n_tick = 0;
        pins(1, 0, 0); chk(n_tick, 0, "rise neg");
        pins(0, 0, 0); chk(n_tick, 1, "fall neg");
        pins(0, 0, 1); chk({is_comp, is_cnt}, 2'b10, "comp owns");
        pins(1, 0, 1); pins(0, 0, 1); chk(n_tick, 1, "comp blk");
        pins(0, 0, 0);
    endtask
    task t_ext_irq;
        wr(spcr_pkg::TIMER_CFG_A, 8'h00);
        n_irq = 0;
        pins(0, 1, 0); chk(n_irq, 1, "irq rise");
        pins(0, 0, 0); chk(n_irq, 1, "irq fall");
        wr(spcr_pkg::TIMER_CFG_A, 8'h80);
        pins(0, 1, 0); chk(n_irq, 1, "irq rise neg");
        pins(0, 0, 0); chk(n_irq, 2, "irq fall neg");
    endtask
    task t_pwm;
        logic [3:0] hi_pat;
        hi_pat = 4'b0100;
        wr(spcr_pkg::PWM_HIGH_A, 8'hff);
        rd(spcr_pkg::PWM_HIGH_A); chk(rd_val, 8'h0f, "pwm high");
        wr(spcr_pkg::PWM_HIGH_A, 8'h00);
        wr(spcr_pkg::PWM_PRD_LO_A, 8'h02);
        wr(spcr_pkg::PWM_DUTY_LO_A, 8'h01);
        wr(spcr_pkg::PWM_CNT_LO_A, 8'h55);
        rd(spcr_pkg::PWM_CNT_LO_A); chk(rd_val, 8'h00, "cnt ro");
        rd(spcr_pkg::PWM_PRD_LO_A); chk(rd_val, 8'h02, "prd rb");
        // Period two, duty one: counts 1 2 0 1
        for (int i = 0; i < 4; i++) begin
            pulse(5);
            chk(pwm_out, hi_pat[i], "pwm walk");
            rd(spcr_pkg::PWM_CNT_LO_A); chk(rd_val, 8'((i + 1) % 3), "cnt walk");
        end
        // Ten-bit period 0x102 and duty 0x100: 256 high of 259 states
        wr(spcr_pkg::PWM_HIGH_A, 8'h05);
        wr(spcr_pkg::PWM_DUTY_LO_A, 8'h00);
        n_hi = 0;
        repeat (518) begin
            pulse(5);
            if (pwm_out === 1'b1) n_hi++;
        end
        chk(n_hi, 512, "pwm duty");
    endtask
    // Reset in mid-run must bring back the config, direction, pad and enable reset values
    task t_mid_reset;
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset;
    endtask

    // ========================================
    // Main sequence and watchdog
    initial begin
        sys_clk = 0;
        rstn = 0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ev, cnt_pin, irq_pin, comp_own} = '0;
        {miscompares, total_checks, n_tick, n_irq} = '0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset;
        t_storage;
        t_dirs;
        t_pads;
        t_gie;
        t_prescale;
        t_ext_count;
        t_ext_irq;
        t_pwm;
        t_mid_reset;
        print_verdict;
    end
    // Whole run needs about 6400 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict;
    end
endmodule
`default_nettype wire
